// >>> shared/adcc_defs.vh
/*
  constants for the converter control block: field layout, reset values,
  timing counts. assumes a 100 MHz system clock; master clock arrives on a pin.
*/
`ifndef ADCC_DEFS_VH
`define ADCC_DEFS_VH
`define ADCC_CAL_W        14
`define ADCC_REG_W        16
`define ADCC_OFFSET_RST   14'h2000
`define ADCC_GAIN_RST     14'h2000
`define ADCC_SETUP_NS     10
`define ADCC_CLK_NS       10
`define ADCC_SETUP_CYC    ((`ADCC_SETUP_NS + `ADCC_CLK_NS - 1) / `ADCC_CLK_NS)
`define ADCC_HALF_CONV    33
`define ADCC_HALF_LATE    35
`define ADCC_SEL_ALL      2'h0
`define ADCC_SEL_BOTH     2'h1
`define ADCC_SEL_OFFSET   2'h2
`define ADCC_SEL_GAIN     2'h3
`define ADCC_PTR_GAIN     4'h0
`define ADCC_PTR_OFFSET   4'h1
`define ADCC_PTR_LAST_ALL 4'h9
`endif

// >>> hdl/adcc_core.v
/*
  converter timing and calibration register access.
  assumes master clock and start arrive asynchronously on pins; the host bus
  is a strobed parallel port already synchronous to clk_i.
*/
`timescale 1ns/1ps
`default_nettype none
`include "adcc_defs.vh"
module adcc_core #(
  parameter CAL_W = `ADCC_CAL_W
) (
  // clock and reset
  input  wire                  clk_i,
  input  wire                  resetn_i,
  // converter pins
  input  wire                  master_clock_input_i,
  input  wire                  conversion_start_n_i,
  output reg                   busy_o,
  output reg                   hold_o,
  // control register write
  input  wire                  ctrl_wr_i,
  input  wire                  ctrl_sw_start_i,
  input  wire                  ctrl_cal_sel_wr_i,
  input  wire                  cal_select_high_i,
  input  wire                  cal_select_low_i,
  // calibration register access and software start flag
  input  wire                  cal_wr_i,
  input  wire                  cal_rd_i,
  input  wire                  byte_mode_i,
  input  wire                  high_byte_enable_i,
  input  wire [15:0]           cal_wdata_i,
  output reg  [15:0]           cal_rdata_o,
  output wire                  sw_start_o,
  output wire [CAL_W-1:0]      offset_correction_o,
  output wire [CAL_W-1:0]      gain_correction_o,
  output wire [3:0]            cal_ptr_o
);
  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  reg [2:0] mclk_sync_reg;
  reg [2:0] start_sync_reg;
  reg       mclk_reg;
  reg       start_n_reg;
  always @(posedge clk_i) begin
    if (!resetn_i) begin
      mclk_sync_reg  <= 3'h0;
      start_sync_reg <= 3'h7;
      mclk_reg       <= 1'b0;
      start_n_reg    <= 1'b1;
    end else begin
      mclk_sync_reg  <= {mclk_sync_reg[1:0], master_clock_input_i};
      start_sync_reg <= {start_sync_reg[1:0], conversion_start_n_i};
      if (mclk_sync_reg[2] == mclk_sync_reg[1])
        mclk_reg <= mclk_sync_reg[1];
      if (start_sync_reg[2] == start_sync_reg[1])
        start_n_reg <= start_sync_reg[1];
    end
  end
  wire mclk_now   = (mclk_sync_reg[2] == mclk_sync_reg[1]) ? mclk_sync_reg[1] : mclk_reg;
  wire start_now  = (start_sync_reg[2] == start_sync_reg[1]) ? start_sync_reg[1] : start_n_reg;
  wire mclk_fall  = mclk_reg & ~mclk_now;
  wire mclk_edge  = mclk_reg ^ mclk_now;
  wire start_rise = ~start_n_reg & start_now;

  // ----------------------------------------
  // conversion sequencer
  // ----------------------------------------
  localparam ST_IDLE = 2'h0;
  localparam ST_WAIT = 2'h1;
  localparam ST_CONV = 2'h2;
  reg [1:0] state_reg;
  reg [5:0] half_cnt_reg;
  reg [5:0] half_target_reg;
  reg [3:0] lead_cnt_reg;
  reg       sw_start_reg;
  wire      trig = start_rise | (ctrl_wr_i & ctrl_sw_start_i);
  always @(posedge clk_i) begin
    if (!resetn_i) begin
      state_reg       <= ST_IDLE;
      half_cnt_reg    <= 6'h0;
      half_target_reg <= 6'h0;
      lead_cnt_reg    <= 4'h0;
      busy_o          <= 1'b0;
      hold_o          <= 1'b0;
      sw_start_reg    <= 1'b0;
    end else begin
      if (ctrl_wr_i && ctrl_sw_start_i && state_reg == ST_IDLE)
        sw_start_reg <= 1'b1;
      case (state_reg)
        ST_IDLE: begin
          if (trig) begin
            hold_o       <= 1'b1;
            lead_cnt_reg <= 4'h0;
            state_reg    <= ST_WAIT;
          end
        end
        ST_WAIT: begin
          if (lead_cnt_reg != 4'hf)
            lead_cnt_reg <= lead_cnt_reg + 4'h1;
          if (mclk_fall) begin
            busy_o       <= 1'b1;
            half_cnt_reg <= 6'h0;
            if (lead_cnt_reg >= `ADCC_SETUP_CYC)
              half_target_reg <= 6'd`ADCC_HALF_CONV;
            else
              half_target_reg <= 6'd`ADCC_HALF_LATE;
            state_reg <= ST_CONV;
          end
        end
        ST_CONV: begin
          if (mclk_edge)
            half_cnt_reg <= half_cnt_reg + 6'h1;
          if (mclk_edge && half_cnt_reg == half_target_reg - 6'h1) begin
            busy_o       <= 1'b0;
            hold_o       <= 1'b0;
            sw_start_reg <= 1'b0;
            state_reg    <= ST_IDLE;
          end
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end
  assign sw_start_o = sw_start_reg;

  // ----------------------------------------
  // calibration registers and pointer
  // ----------------------------------------
  reg [CAL_W-1:0] offset_reg;
  reg [CAL_W-1:0] gain_reg;
  reg [1:0]       sel_reg;
  reg [3:0]       ptr_reg;
  wire [1:0]      sel_in    = {cal_select_high_i, cal_select_low_i};
  wire [3:0]      ptr_start = (sel_in == `ADCC_SEL_OFFSET) ? `ADCC_PTR_OFFSET : `ADCC_PTR_GAIN;
  wire [3:0]      ptr_last  = (sel_reg == `ADCC_SEL_ALL)  ? `ADCC_PTR_LAST_ALL :
                              (sel_reg == `ADCC_SEL_BOTH) ? `ADCC_PTR_OFFSET :
                              (sel_reg == `ADCC_SEL_OFFSET) ? `ADCC_PTR_OFFSET : `ADCC_PTR_GAIN;
  wire [3:0]      ptr_first = (sel_reg == `ADCC_SEL_OFFSET) ? `ADCC_PTR_OFFSET : `ADCC_PTR_GAIN;
  wire            access    = cal_wr_i | cal_rd_i;
  wire            done_word = access & (~byte_mode_i | high_byte_enable_i);
  always @(posedge clk_i) begin
    if (!resetn_i) begin
      offset_reg  <= `ADCC_OFFSET_RST;
      gain_reg    <= `ADCC_GAIN_RST;
      sel_reg     <= `ADCC_SEL_ALL;
      ptr_reg     <= `ADCC_PTR_GAIN;
      cal_rdata_o <= 16'h0;
    end else begin
      if (ctrl_cal_sel_wr_i) begin
        sel_reg <= sel_in;
        ptr_reg <= ptr_start;
      end else begin
        if (cal_wr_i && ptr_reg == `ADCC_PTR_OFFSET) begin
          if (!byte_mode_i)
            offset_reg <= cal_wdata_i[CAL_W-1:0];
          else if (!high_byte_enable_i)
            offset_reg[7:0] <= cal_wdata_i[7:0];
          else
            offset_reg[CAL_W-1:8] <= cal_wdata_i[CAL_W-9:0];
        end
        if (cal_wr_i && ptr_reg == `ADCC_PTR_GAIN) begin
          if (!byte_mode_i)
            gain_reg <= cal_wdata_i[CAL_W-1:0];
          else if (!high_byte_enable_i)
            gain_reg[7:0] <= cal_wdata_i[7:0];
          else
            gain_reg[CAL_W-1:8] <= cal_wdata_i[CAL_W-9:0];
        end
        if (cal_rd_i) begin
          if (ptr_reg == `ADCC_PTR_OFFSET)
            cal_rdata_o <= {2'h0, offset_reg};
          else if (ptr_reg == `ADCC_PTR_GAIN)
            cal_rdata_o <= {2'h0, gain_reg};
          else
            cal_rdata_o <= 16'h0;
        end
        if (done_word)
          ptr_reg <= (ptr_reg == ptr_last) ? ptr_first : ptr_reg + 4'h1;
      end
    end
  end
  assign offset_correction_o = offset_reg;
  assign gain_correction_o   = gain_reg;
  assign cal_ptr_o           = ptr_reg;
endmodule
`default_nettype wire

// >>> tb/adcc_core_sva.sv
/* checker on adcc_core ports: start, busy, hold, pointer, read data.
   assumes it is bound to every adcc_core instance with matching port names. */
`timescale 1ns/1ps
`default_nettype none
module adcc_chk (
  input wire logic        clk_i, resetn_i, busy_o, hold_o, sw_start_o,
  input wire logic        ctrl_wr_i, ctrl_sw_start_i, ctrl_cal_sel_wr_i,
  input wire logic        cal_select_high_i, cal_select_low_i,
  input wire logic [15:0] cal_rdata_o,
  input wire logic [3:0]  cal_ptr_o
);
  logic [9:0] n_busy;
  always @(posedge clk_i) begin
    if (!resetn_i) n_busy <= 10'h0;
    else n_busy <= busy_o ? n_busy + 10'h1 : 10'h0;
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  sw_hold_a: assert property (ctrl_wr_i && ctrl_sw_start_i && !hold_o |=> hold_o && sw_start_o)
    else $error("no hold after software start");
  busy_len_a: assert property ($fell(busy_o) |-> n_busy >= 10'h195 && n_busy <= 10'h1bd)
    else $error("busy length out of range");
  busy_max_a: assert property (busy_o |-> n_busy < 10'h1c2)
    else $error("busy too long");
  sw_clear_a: assert property ($fell(busy_o) |-> !sw_start_o && !hold_o)
    else $error("start bit or hold left set");
  busy_begin_a: assert property ($rose(hold_o) |-> ##[1:40] $rose(busy_o))
    else $error("busy did not rise");
  busy_hold_a: assert property (busy_o |-> hold_o)
    else $error("busy without hold");
  read_zero_a: assert property (cal_rdata_o[15:14] == 2'h0)
    else $error("read data top bits set");
  sel_ptr_a: assert property (ctrl_cal_sel_wr_i |=>
    cal_ptr_o == {3'h0, $past(cal_select_high_i) & ~$past(cal_select_low_i)})
    else $error("pointer not reset to first of set");
endmodule
bind adcc_core adcc_chk i_chk (.*);
`default_nettype wire

// >>> tb/adcc_host_model.sv
/* host side model: master clock pin and start pin.
   assumes the bench calls pulse() with the start lead in ns. */
`timescale 1ns/1ps
`default_nettype none
module adcc_host_model (
  output logic master_clk_o,
  output logic start_n_o
);
  initial begin
    master_clk_o = 1'b0;
    // offset keeps master edges clear of system clock edges
    #2;
    forever #125 master_clk_o = ~master_clk_o;
  end
  initial start_n_o = 1'b1;
  // low pulse, rising edge leads a master falling edge, no bus traffic
  task automatic pulse(input int lead_ns);
    @(posedge master_clk_o);
    start_n_o = 1'b0;
    #(125 - lead_ns) start_n_o = 1'b1;
  endtask
endmodule
`default_nettype wire

// >>> tb/tb_adcc_core.sv
/* bench for adcc_core: calibration access and conversion timing.
   assumes adcc_defs.vh on the include path and the host model beside it. */
`timescale 1ns/1ps
`default_nettype none
`include "adcc_defs.vh"
module tb_adcc_core;
  logic clk_i = 0, resetn_i = 0, ctrl_wr_i = 0, ctrl_sw_start_i = 0, ctrl_cal_sel_wr_i = 0;
  logic cal_select_high_i = 0, cal_select_low_i = 0, cal_wr_i = 0, cal_rd_i = 0;
  logic byte_mode_i = 0, high_byte_enable_i = 0, busy_o, hold_o, sw_start_o;
  logic master_clock_input_i, conversion_start_n_i;
  logic [15:0] cal_wdata_i = 0, cal_rdata_o;
  logic [13:0] offset_correction_o, gain_correction_o;
  logic [3:0]  cal_ptr_o;
  int failures = 0, n_tests = 0, n;
  initial forever #5 clk_i = ~clk_i;
  adcc_host_model i_host (.master_clk_o(master_clock_input_i), .start_n_o(conversion_start_n_i));
  adcc_core i_dut (.*);
  task cyc(input int k = 1);
    repeat (k) @(posedge clk_i);
    #1;
  endtask
  task check(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task end_of_test;
    if (failures == 0 && n_tests > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task sel(input logic [1:0] s);
    {cal_select_high_i, cal_select_low_i} = s;
    ctrl_cal_sel_wr_i = 1;
    cyc();
    ctrl_cal_sel_wr_i = 0;
    cyc();
  endtask
  task acc(input logic rd, input logic [15:0] d, input logic b = 0, input logic h = 0);
    {cal_wdata_i, byte_mode_i, high_byte_enable_i} = {d, b, h};
    {cal_rd_i, cal_wr_i} = {rd, !rd};
    cyc();
    {cal_rd_i, cal_wr_i} = 2'h0;
    cyc();
  endtask
  // lead below zero: software start, else pin start with lead in ns
  task conv(input int lead, input int exp);
    if (lead < 0) begin
      {ctrl_wr_i, ctrl_sw_start_i} = 2'h3;
      cyc();
      {ctrl_wr_i, ctrl_sw_start_i} = 2'h0;
      check(sw_start_o, 1);
    end else i_host.pulse(lead);
    n = 0;
    while (hold_o !== 1'b1 && n < 60) begin cyc(); n++; end
    if (n >= 60) begin failures++; end_of_test; end
    n = 0;
    while (hold_o === 1'b1 && n < 500) begin cyc(); n++; end
    if (n >= 500) begin failures++; end_of_test; end
    check(sw_start_o, 0);
    check(busy_o, 0);
    if (exp > 0) check(16'(n >= exp - 4 && n <= exp + 4), 1);
    cyc(38); // acquisition of 1.5 master periods
  endtask
  initial begin
    cyc(10);
    resetn_i = 1;
    cyc(3);
    check(offset_correction_o, `ADCC_OFFSET_RST);
    check(gain_correction_o, `ADCC_GAIN_RST);
    sel(2'h3); check(cal_ptr_o, 0);
    acc(0, 16'hffff); check(gain_correction_o, 14'h3fff);
    acc(1, 0); check(cal_rdata_o, 16'h3fff);
    sel(2'h2); check(cal_ptr_o, 1);
    acc(0, 16'h051f); check(offset_correction_o, 14'h051f);
    acc(1, 0); check(cal_rdata_o, 16'h051f);
    sel(2'h1); acc(0, 16'h0123); check(cal_ptr_o, 1); check(gain_correction_o, 14'h0123);
    acc(0, 16'h0456); check(cal_ptr_o, 0); check(offset_correction_o, 14'h0456);
    acc(0, 16'h00ab, 1, 0); check(cal_ptr_o, 0);
    acc(0, 16'h1515, 1, 1); check(cal_ptr_o, 1); check(gain_correction_o, 14'h15ab);
    sel(2'h0);
    for (int i = 1; i <= 10; i++) begin acc(0, 0); check(cal_ptr_o, i % 10); end
    conv(-1, 0);
    conv(60, 6 + `ADCC_HALF_CONV * 125 / 10);
    conv(2, `ADCC_HALF_LATE * 125 / 10);
    end_of_test;
  end
endmodule
`default_nettype wire
